// ---- shared/erwc_params.svh ----
// Constants of the external bus ready/wait controller
`ifndef ERWC_PARAMS_SVH
`define ERWC_PARAMS_SVH
`define ERWC_LEN_W 5
`define ERWC_CNT_W 6
`define ERWC_WIN_W 2
`define ERWC_NWIN 4
`define ERWC_CNT_RST 6'h00
`define ERWC_STROBE_RST 1'h1
`define ERWC_TGL_RST 1'h0
`endif

// ---- shared/erwc_pkg.sv ----
// Types of the external bus ready/wait controller
`include "erwc_params.svh"
package erwc_pkg;
    typedef enum logic [1:0] {
        ERWC_IDLE   = 2'h0,
        ERWC_ACCESS = 2'h1,
        ERWC_END    = 2'h2
    } erwc_link_state_type;

    typedef struct packed {
        logic                   req_tgl;
        logic [1:0]             ack_sync;
        logic                   ack_seen;
        logic                   busy;
        logic                   done;
        logic [`ERWC_LEN_W-1:0] len;
        logic                   write;
        logic                   async_mode;
        logic                   pol_high;
    } erwc_core_type;

    typedef struct packed {
        logic                   rst_meta;
        logic                   rst_sync;
        logic                   req_meta;
        logic                   req_sync;
        logic                   req_seen;
        logic                   rdy_samp;
        logic                   rdy_meta;
        logic                   rdy_sync;
        erwc_link_state_type    state;
        logic [`ERWC_CNT_W-1:0] cnt;
        logic                   rd_n;
        logic                   wr_n;
        logic                   wait_phase;
        logic                   ack_tgl;
    } erwc_link_type;
endpackage

// ---- hdl/erwc_ctrl.sv ----
// External bus cycle control with ready-driven wait states
// Functional notes
// RULE_01 - Each external cycle is stretched or ended by the ready input as it is seen.
// RULE_02 - Ready polarity is selectable, either level can mean ready.
// RULE_03 - Synchronous ready is sampled by one flop on the reference clock, no synchronizer.
// RULE_04 - Asynchronous ready passes an extra synchronizer stage, adding a wait state.
// RULE_05 - Asynchronous ready must stay active one reference period plus setup time.
// RULE_06 - The external circuit may drop ready after the trailing edge of the strobe.
// RULE_07 - Ready must be inactive again before the first sample point of the next cycle.
// RULE_08 - The first ready sample point follows the programmed access phase length.
// RULE_09 - Ready seen inactive at a sample point adds one wait phase and samples again.
// RULE_10 - Ready seen active at a sample point ends the running cycle.
// RULE_11 - Synchronous and asynchronous modes use different sample points.
// RULE_12 - Mandatory access wait states finish before ready is evaluated.
// RULE_13 - Ready mode and polarity are chosen per address window.
`timescale 1ns/1ps
`include "erwc_params.svh"
module erwc_ctrl (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    bus_ref_clk,
    input  wire logic                    req_valid,
    input  wire logic [`ERWC_WIN_W-1:0]  req_win,
    input  wire logic                    req_write,
    input  wire logic [`ERWC_LEN_W-1:0]  req_len,
    input  wire logic [`ERWC_NWIN-1:0]   win_async,
    input  wire logic [`ERWC_NWIN-1:0]   win_ready_high,
    input  wire logic                    ready_in,
    output logic                         busy,
    output logic                         done,
    output logic                         rd_n,
    output logic                         wr_n,
    output logic                         ready_wait
);
    erwc_pkg::erwc_core_type c_reg;
    erwc_pkg::erwc_core_type c_next;
    erwc_pkg::erwc_link_type l_reg;
    erwc_pkg::erwc_link_type l_next;
    logic                    link_rst;
    logic                    rdy_act;
    logic                    at_sample;
    logic                    req_edge;
    logic                    sel_async;
    logic                    sel_pol;
    logic [`ERWC_CNT_W-1:0]  last_cnt;

    // Ready counts as active when the sampled level matches the window's polarity
    function automatic logic ready_match(input logic level, input logic pol);
        ready_match = (level == pol);
    endfunction

    assign link_rst  = l_reg.rst_sync;
    assign req_edge  = l_reg.req_sync != l_reg.req_seen;
    assign sel_async = win_async[req_win];
    assign sel_pol   = win_ready_high[req_win];
    // Async mode moves the first sample point one period later
    assign last_cnt  = {1'b0, c_reg.len} + {5'h00, c_reg.async_mode};  // see RULE_08, RULE_11
    assign at_sample = (l_reg.state == erwc_pkg::ERWC_ACCESS) && (l_reg.cnt >= last_cnt);
    // Polarity compare; the mode picks the plain sample or the synchronised one
    assign rdy_act   = c_reg.async_mode
                       ? ready_match(l_reg.rdy_sync, c_reg.pol_high)   // see RULE_04
                       : ready_match(l_reg.rdy_samp, c_reg.pol_high);  // see RULE_02, RULE_03

    // Core side: request capture and completion handshake
    always_comb begin
        c_next          = c_reg;
        c_next.done     = 1'b0;
        c_next.ack_sync = {c_reg.ack_sync[0], l_reg.ack_tgl};
        c_next.ack_seen = c_reg.ack_sync[1];
        if (c_reg.busy && (c_reg.ack_sync[1] != c_reg.ack_seen)) begin
            c_next.busy = 1'b0;
            c_next.done = 1'b1;
        end else if (!c_reg.busy && req_valid) begin
            // Word stays still until the ack returns, so the link may read it directly
            c_next.busy       = 1'b1;
            c_next.req_tgl    = ~c_reg.req_tgl;
            c_next.len        = req_len;
            c_next.write      = req_write;
            c_next.async_mode = sel_async;  // see RULE_13
            c_next.pol_high   = sel_pol;    // see RULE_13
        end
        if (rst) begin
            c_next          = '0;
            c_next.req_tgl  = `ERWC_TGL_RST;
        end
    end

    always_ff @(posedge clk) begin
        c_reg <= c_next;
    end

    // Link side: runs on the bus reference clock
    always_comb begin
        l_next          = l_reg;
        l_next.rst_meta = rst;
        l_next.rst_sync = l_reg.rst_meta;
        l_next.req_meta = c_reg.req_tgl;
        l_next.req_sync = l_reg.req_meta;
        l_next.req_seen = l_reg.req_sync;
        l_next.rdy_samp = ready_in;            // see RULE_03
        l_next.rdy_meta = ready_in;            // see RULE_04
        l_next.rdy_sync = l_reg.rdy_meta;
        unique case (l_reg.state)
            erwc_pkg::ERWC_IDLE: begin
                if (req_edge) begin
                    l_next.state      = erwc_pkg::ERWC_ACCESS;
                    l_next.cnt        = `ERWC_CNT_RST;
                    l_next.rd_n       = c_reg.write;
                    l_next.wr_n       = ~c_reg.write;
                    l_next.wait_phase = 1'b0;
                end
            end
            erwc_pkg::ERWC_ACCESS: begin
                if (!at_sample) begin
                    l_next.cnt = l_reg.cnt + 6'h01;  // see RULE_12
                end else if (rdy_act) begin
                    l_next.state      = erwc_pkg::ERWC_END;  // see RULE_10
                    l_next.rd_n       = 1'b1;
                    l_next.wr_n       = 1'b1;
                    l_next.wait_phase = 1'b0;
                    l_next.ack_tgl    = ~l_reg.ack_tgl;
                end else begin
                    l_next.wait_phase = 1'b1;  // see RULE_09, RULE_01
                end
            end
            erwc_pkg::ERWC_END: begin
                // One idle period lets ready fall before the next sample point
                l_next.state = erwc_pkg::ERWC_IDLE;  // see RULE_07
            end
            default: begin
                l_next.state = erwc_pkg::ERWC_IDLE;
            end
        endcase
        if (link_rst) begin
            l_next.req_meta   = 1'b0;
            l_next.req_sync   = 1'b0;
            l_next.req_seen   = 1'b0;
            l_next.state      = erwc_pkg::ERWC_IDLE;
            l_next.cnt        = `ERWC_CNT_RST;
            l_next.rd_n       = `ERWC_STROBE_RST;
            l_next.wr_n       = `ERWC_STROBE_RST;
            l_next.wait_phase = 1'b0;
            l_next.ack_tgl    = `ERWC_TGL_RST;
        end
    end

    always_ff @(posedge bus_ref_clk) begin
        l_reg <= l_next;
    end

    assign busy       = c_reg.busy;
    assign done       = c_reg.done;
    assign rd_n       = l_reg.rd_n;
    assign wr_n       = l_reg.wr_n;
    assign ready_wait = l_reg.wait_phase;

    sequence s_start;
        (l_reg.state == erwc_pkg::ERWC_IDLE) && req_edge;
    endsequence

    sequence s_ready_seen;
        at_sample && rdy_act;
    endsequence

    a_strobe_start: assert property (@(posedge bus_ref_clk) disable iff (link_rst) // see RULE_01
        s_start |=> (l_reg.state == erwc_pkg::ERWC_ACCESS) && (l_reg.rd_n != l_reg.wr_n))
        else $error("strobe not driven at cycle start");

    a_ready_ends: assert property (@(posedge bus_ref_clk) disable iff (link_rst) // see RULE_10
        s_ready_seen |=> (l_reg.state == erwc_pkg::ERWC_END) && l_reg.rd_n && l_reg.wr_n
                         ##1 (l_reg.state == erwc_pkg::ERWC_IDLE))
        else $error("cycle did not end on ready");

    a_not_ready_waits: assert property (@(posedge bus_ref_clk) disable iff (link_rst) // see RULE_09
        at_sample && !rdy_act |=> (l_reg.state == erwc_pkg::ERWC_ACCESS) && l_reg.wait_phase)
        else $error("no wait phase on inactive ready");

    a_mandatory_phase: assert property (@(posedge bus_ref_clk) disable iff (link_rst) // see RULE_12
        (l_reg.state == erwc_pkg::ERWC_ACCESS) && !at_sample
        |=> (l_reg.state == erwc_pkg::ERWC_ACCESS) && !l_reg.wait_phase
            && (l_reg.cnt == $past(l_reg.cnt) + 6'h01))
        else $error("access phase cut short");

    a_first_sample: assert property (@(posedge bus_ref_clk) disable iff (link_rst) // see RULE_08
        s_start ##1 (c_reg.len == 5'h04) && !c_reg.async_mode
        |-> !at_sample [*4] ##1 at_sample)
        else $error("first sample point misplaced");

    a_async_delay: assert property (@(posedge bus_ref_clk) disable iff (link_rst) // see RULE_04
        s_start ##1 c_reg.async_mode |-> (l_reg.state != erwc_pkg::ERWC_END) [*2])
        else $error("async cycle shorter than two periods");

    a_sync_polarity: assert property (@(posedge bus_ref_clk) disable iff (link_rst) // see RULE_02
        at_sample && !c_reg.async_mode && (l_reg.rdy_samp != c_reg.pol_high)
        |=> l_reg.state != erwc_pkg::ERWC_END)
        else $error("wrong ready polarity honoured");

    a_sync_sample: assert property (@(posedge bus_ref_clk) disable iff (link_rst) // see RULE_03
        at_sample && !c_reg.async_mode && (l_reg.rdy_samp == c_reg.pol_high)
        |=> l_reg.state == erwc_pkg::ERWC_END)
        else $error("sync ready sample ignored");

    a_end_idle: assert property (@(posedge bus_ref_clk) disable iff (link_rst) // see RULE_07
        l_reg.state == erwc_pkg::ERWC_END |=> l_reg.state == erwc_pkg::ERWC_IDLE)
        else $error("no gap after cycle end");

    a_window_config: assert property (@(posedge clk) disable iff (rst) // see RULE_13
        !c_reg.busy && req_valid
        |=> c_reg.busy && (c_reg.async_mode == $past(sel_async))
            && (c_reg.pol_high == $past(sel_pol)))
        else $error("window ready config not taken");

    a_async_sample: assert property (@(posedge bus_ref_clk) disable iff (link_rst) // see RULE_11
        at_sample && c_reg.async_mode && (l_reg.rdy_sync == c_reg.pol_high)
        |=> l_reg.state == erwc_pkg::ERWC_END)
        else $error("async ready sample ignored");

    a_idle_no_wait: assert property (@(posedge bus_ref_clk) disable iff (link_rst) // see RULE_09
        l_reg.state == erwc_pkg::ERWC_IDLE |-> !l_reg.wait_phase)
        else $error("wait phase left on between cycles");

    a_done_pulse: assert property (@(posedge clk) disable iff (rst) // see RULE_10
        c_reg.done |-> !c_reg.busy ##1 !c_reg.done)
        else $error("done not a single cycle pulse");
endmodule // erwc_ctrl

// ---- tb/erwc_ready_partner.sv ----
// External circuit model that answers each strobe with a ready level
`timescale 1ns/1ps
module erwc_ready_partner (
    input  wire logic       bus_ref_clk,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       pol_high,
    input  wire logic [5:0] delay,
    output logic            ready_in
);
    logic [5:0] seen_reg = 6'h00;
    initial ready_in = 1'h0;
    // Ready only moves just after a reference edge, so it is synchronous
    always @(posedge bus_ref_clk) begin
        if (!(rd_n && wr_n)) begin
            seen_reg <= seen_reg + 6'h01;
            // Once active it stays so until the strobe ends, well over a period
            ready_in <= ((seen_reg + 6'h01) >= delay) ? pol_high : !pol_high;
        end else begin
            seen_reg <= 6'h00;
            // Dropped after the trailing strobe edge, before the next sample point
            ready_in <= !pol_high;
        end
    end
endmodule // erwc_ready_partner

// ---- tb/erwc_ctrl_test.sv ----
// Self-checking bench for the ready-controlled external bus cycle
`timescale 1ns/1ps
module erwc_ctrl_test;
    logic       clk = 1'h0;
    logic       rst = 1'h1;
    logic       bus_ref_clk = 1'h0;
    logic       req_valid = 1'h0;
    logic [1:0] req_win = 2'h0;
    logic       req_write = 1'h0;
    logic [4:0] req_len = 5'h00;
    logic [3:0] win_async = 4'h2;
    logic [3:0] win_ready_high = 4'hB;
    logic       ready_in, busy, done, rd_n, wr_n, ready_wait;
    logic       pol_high = 1'h1;
    logic [5:0] delay = 6'h01;
    logic [7:0] low_cnt = 8'h00;
    logic       wait_seen = 1'h0;
    logic       other_low = 1'h0;
    int         fails = 0;
    int         tests_run = 0;
    logic [7:0] a, b;

    erwc_ctrl u_dut (.clk(clk), .rst(rst), .bus_ref_clk(bus_ref_clk), .req_valid(req_valid),
        .req_win(req_win), .req_write(req_write), .req_len(req_len), .win_async(win_async),
        .win_ready_high(win_ready_high), .ready_in(ready_in), .busy(busy), .done(done),
        .rd_n(rd_n), .wr_n(wr_n), .ready_wait(ready_wait));
    erwc_ready_partner u_partner (.bus_ref_clk(bus_ref_clk), .rd_n(rd_n), .wr_n(wr_n),
        .pol_high(pol_high), .delay(delay), .ready_in(ready_in));

    initial forever #10 clk = ~clk;
    initial begin
        #3;
        forever #16 bus_ref_clk = ~bus_ref_clk;
    end
    // Strobe width in reference periods, sampled mid-period to stay clear of the edge
    always @(negedge bus_ref_clk) begin
        if ((req_write ? wr_n : rd_n) === 1'h0) low_cnt <= low_cnt + 8'h01;
        if ((req_write ? rd_n : wr_n) !== 1'h1) other_low <= 1'h1;
        if (ready_wait === 1'h1) wait_seen <= 1'h1;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One cycle on a window; width is the strobe length in reference periods
    task automatic run(input logic [1:0] win, input logic wr, input logic [4:0] len,
                       input logic [5:0] dly, output logic [7:0] width);
        int n;
        @(posedge clk);
        pol_high <= win_ready_high[win];
        delay <= dly;
        req_win <= win;
        req_write <= wr;
        req_len <= len;
        repeat (8) @(posedge clk);
        low_cnt <= 8'h00;
        wait_seen <= 1'h0;
        other_low <= 1'h0;
        req_valid <= 1'h1;
        @(posedge clk);
        req_valid <= 1'h0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (done !== 1'h1 && n < 3000);
        chk({7'h00, done}, 8'h01);
        width = low_cnt;
        @(negedge clk);
        chk({6'h00, done, busy}, 8'h00);
    endtask

    task automatic t_reset();
        chk({3'h0, busy, done, rd_n, wr_n, ready_wait}, 8'h06);
    endtask
    task automatic t_access_len();
        run(2'h0, 1'h0, 5'h04, 6'h01, a);
        chk({7'h00, wait_seen}, 8'h00);
        run(2'h0, 1'h0, 5'h05, 6'h01, b);
        chk(b - a, 8'h01);
    endtask
    task automatic t_ready_wait();
        run(2'h0, 1'h0, 5'h00, 6'h04, a);
        chk({7'h00, wait_seen}, 8'h01);
        run(2'h0, 1'h0, 5'h00, 6'h08, b);
        chk(b - a, 8'h04);
    endtask
    task automatic t_async();
        run(2'h0, 1'h0, 5'h04, 6'h01, a);
        run(2'h1, 1'h0, 5'h04, 6'h01, b);
        chk(b - a, 8'h01);
    endtask
    task automatic t_polarity();
        run(2'h0, 1'h0, 5'h00, 6'h04, a);
        run(2'h2, 1'h0, 5'h00, 6'h04, b);
        chk(b, a);
    endtask
    task automatic t_write();
        run(2'h0, 1'h0, 5'h04, 6'h01, a);
        run(2'h3, 1'h1, 5'h04, 6'h01, b);
        chk(b, a);
        chk({7'h00, other_low}, 8'h00);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        #1;
        t_reset();
        @(posedge clk);
        rst <= 1'h0;
        repeat (10) @(posedge clk);
        t_access_len();
        t_ready_wait();
        t_async();
        t_polarity();
        t_write();
        close_out();
    end
    // Ten short cycles need about 6 us; this cuts a hang short
    initial begin
        #50us;
        fails++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
        close_out();
    end
endmodule // erwc_ctrl_test
